// *** core/payload_checker.sv ***
// Purpose: receives speed and feedback payloads, checks crc and sequence, decodes fields
// Assumes: link bytes come from logic on mclk, one frame at a time
// Notes: decoded fields change only on an accepted frame
`timescale 1ns/10ps
module payload_checker
   import can_payload_pkg::*;
#(
   parameter int unsigned SPEED_STALE_CYC = STALE_PERIODS * SPEED_PERIOD_MS * CLK_KHZ,
   parameter int unsigned FEEDBACK_STALE_CYC = STALE_PERIODS * FEEDBACK_PERIOD_MS * CLK_KHZ
)
(
   input wire logic mclk,
   input wire logic srst,
   can_payload_if.receiver link,
   input wire logic seq_check_en,
   output logic msg_ok,
   output logic crc_error,
   output logic seq_error,
   output logic rx_kind,
   output logic rx_channel,
   output logic [1:0] travel_direction,
   output logic [15:0] vehicle_speed_value,
   output logic speed_not_available,
   output logic [15:0] estimated_flow,
   output logic flow_not_available,
   output logic [15:0] estimated_wheel_angle,
   output logic angle_not_available,
   output logic [7:0] lock_to_lock_revolutions,
   output logic l2l_not_available,
   output logic l2l_reserved,
   output logic speed_stale,
   output logic feedback_stale
);
   // ***************************************************************
   // frame capture state
   // ***************************************************************
   logic [2:0] idx_reg;
   logic busy_reg;
   logic kind_reg;
   logic chan_reg;
   logic [7:0] buf_reg [0:5];
   logic [15:0] crc_reg;
   logic [7:0] crc_lo_reg;
   logic [3:0] last_seq_reg [0:3];
   logic [3:0] seen_reg;
   // ***************************************************************
   // output registers
   // ***************************************************************
   logic ok_reg;
   logic crc_err_reg;
   logic seq_err_reg;
   logic rx_kind_reg;
   logic rx_chan_reg;
   logic [1:0] dir_reg;
   logic [15:0] speed_reg;
   logic speed_na_reg;
   logic [15:0] flow_reg;
   logic flow_na_reg;
   logic [15:0] angle_reg;
   logic angle_na_reg;
   logic [7:0] l2l_reg;
   logic l2l_na_reg;
   logic l2l_rsv_reg;
   logic [STALE_CNT_W-1:0] speed_cnt_reg;
   logic [STALE_CNT_W-1:0] fb_cnt_reg;
   logic speed_stale_reg;
   logic fb_stale_reg;
   // ***************************************************************
   // byte intake
   // ***************************************************************
   // a fresh byte_first always restarts the frame, so a cut-off frame
   // is dropped silently rather than merged with the next one
   wire take = link.byte_valid;
   wire start = take & link.byte_first;
   wire cont = take & ~link.byte_first & busy_reg;
   wire in_payload = idx_reg <= PAYLOAD_LAST_IDX;
   wire [15:0] crc_seed = start ? CRC_INIT : crc_reg;
   wire [15:0] crc_step;
   wire frame_end = cont & (idx_reg == CRC_HI_IDX);

   crc16_byte_step crc_u (
      .crc_in(crc_seed),
      .data_in(link.byte_data),
      .crc_out(crc_step)
   );
   // ***************************************************************
   // frame checks
   // ***************************************************************
   wire [15:0] rx_crc = {link.byte_data, crc_lo_reg};
   wire crc_ok = rx_crc == crc_reg;
   wire [1:0] stream = {kind_reg, chan_reg};
   wire [3:0] rx_seq = buf_reg[SEQ_IDX][3:0];
   wire [3:0] exp_seq = last_seq_reg[stream] + SEQ_STEP;
   // first frame of a stream after reset only sets the reference
   wire seq_ok = ~seq_check_en | ~seen_reg[stream] | (rx_seq == exp_seq);
   wire accept = frame_end & crc_ok & seq_ok;
   wire accept_speed = accept & (kind_reg == KIND_SPEED);
   wire accept_fb = accept & (kind_reg == KIND_FEEDBACK);
   // ***************************************************************
   // field decode
   // ***************************************************************
   wire [1:0] dir_field = buf_reg[DIR_IDX][7:6];
   wire [15:0] speed_field = {buf_reg[SPEED_HI_IDX], buf_reg[SPEED_LO_IDX]};
   wire [15:0] flow_field = {buf_reg[FLOW_HI_IDX], buf_reg[FLOW_LO_IDX]};
   wire [15:0] angle_field = {buf_reg[ANGLE_HI_IDX], buf_reg[ANGLE_LO_IDX]};
   wire [7:0] l2l_field = buf_reg[L2L_IDX];
   wire l2l_na = l2l_field == L2L_NA;
   wire l2l_rsv = ~l2l_na & ((l2l_field < L2L_MIN) | (l2l_field > L2L_MAX));
   wire [STALE_CNT_W-1:0] speed_limit = STALE_CNT_W'(SPEED_STALE_CYC);
   wire [STALE_CNT_W-1:0] fb_limit = STALE_CNT_W'(FEEDBACK_STALE_CYC);
   // ***************************************************************
   // capture
   // ***************************************************************
   always_ff @(posedge mclk) begin
      if (start) begin
         buf_reg[0] <= link.byte_data;
      end else if (cont & in_payload) begin
         buf_reg[idx_reg] <= link.byte_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         idx_reg <= 3'h0;
         busy_reg <= 1'b0;
         kind_reg <= 1'b0;
         chan_reg <= 1'b0;
         crc_reg <= CRC_INIT;
         crc_lo_reg <= 8'h00;
      end else if (start) begin
         idx_reg <= 3'h1;
         busy_reg <= 1'b1;
         kind_reg <= link.msg_kind;
         chan_reg <= link.msg_channel;
         crc_reg <= crc_step;
      end else if (cont) begin
         idx_reg <= idx_reg + 3'h1;
         if (in_payload) begin
            crc_reg <= crc_step;
         end
         if (idx_reg == CRC_LO_IDX) begin
            crc_lo_reg <= link.byte_data;
         end
         if (frame_end) begin
            busy_reg <= 1'b0;
         end
      end
   end
   // ***************************************************************
   // verdict and sequence tracking
   // ***************************************************************
   always_ff @(posedge mclk) begin
      if (srst) begin
         ok_reg <= 1'b0;
         crc_err_reg <= 1'b0;
         seq_err_reg <= 1'b0;
         rx_kind_reg <= 1'b0;
         rx_chan_reg <= 1'b0;
         seen_reg <= 4'h0;
         for (int i = 0; i < 4; i++) begin
            last_seq_reg[i] <= 4'h0;
         end
      end else begin
         ok_reg <= accept;
         crc_err_reg <= frame_end & ~crc_ok;
         seq_err_reg <= frame_end & crc_ok & ~seq_ok;
         if (frame_end) begin
            rx_kind_reg <= kind_reg;
            rx_chan_reg <= chan_reg;
         end
         // a crc-clean frame resyncs the reference even when its number jumped,
         // so one lost frame costs one error, not a run of them
         if (frame_end & crc_ok) begin
            last_seq_reg[stream] <= rx_seq;
            seen_reg[stream] <= 1'b1;
         end
      end
   end
   // ***************************************************************
   // decoded fields
   // ***************************************************************
   always_ff @(posedge mclk) begin
      if (srst) begin
         dir_reg <= DIR_NA;
         speed_reg <= 16'hFFFF;
         speed_na_reg <= 1'b1;
      end else if (accept_speed) begin
         dir_reg <= dir_field;
         speed_reg <= speed_field;
         speed_na_reg <= speed_field > SPEED_MAX;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         flow_reg <= 16'hFFFF;
         flow_na_reg <= 1'b1;
         angle_reg <= 16'hFFFF;
         angle_na_reg <= 1'b1;
         l2l_reg <= L2L_NA;
         l2l_na_reg <= 1'b1;
         l2l_rsv_reg <= 1'b0;
      end else if (accept_fb) begin
         flow_reg <= flow_field;
         flow_na_reg <= flow_field > POSITION_MAX;
         angle_reg <= angle_field;
         angle_na_reg <= angle_field > POSITION_MAX;
         l2l_reg <= l2l_field;
         l2l_na_reg <= l2l_na;
         l2l_rsv_reg <= l2l_rsv;
      end
   end
   // ***************************************************************
   // arrival watchdogs
   // ***************************************************************
   // only accepted frames feed the watchdog; a stream of corrupt frames looks
   // the same as silence, which is the safe reading
   always_ff @(posedge mclk) begin
      if (srst | accept_speed) begin
         speed_cnt_reg <= '0;
         speed_stale_reg <= 1'b0;
      end else if (speed_cnt_reg < speed_limit) begin
         speed_cnt_reg <= speed_cnt_reg + 1'b1;
      end else begin
         speed_stale_reg <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst | accept_fb) begin
         fb_cnt_reg <= '0;
         fb_stale_reg <= 1'b0;
      end else if (fb_cnt_reg < fb_limit) begin
         fb_cnt_reg <= fb_cnt_reg + 1'b1;
      end else begin
         fb_stale_reg <= 1'b1;
      end
   end
   // ***************************************************************
   // outputs
   // ***************************************************************
   assign msg_ok = ok_reg;
   assign crc_error = crc_err_reg;
   assign seq_error = seq_err_reg;
   assign rx_kind = rx_kind_reg;
   assign rx_channel = rx_chan_reg;
   assign travel_direction = dir_reg;
   assign vehicle_speed_value = speed_reg;
   assign speed_not_available = speed_na_reg;
   assign estimated_flow = flow_reg;
   assign flow_not_available = flow_na_reg;
   assign estimated_wheel_angle = angle_reg;
   assign angle_not_available = angle_na_reg;
   assign lock_to_lock_revolutions = l2l_reg;
   assign l2l_not_available = l2l_na_reg;
   assign l2l_reserved = l2l_rsv_reg;
   assign speed_stale = speed_stale_reg;
   assign feedback_stale = fb_stale_reg;
endmodule : payload_checker

// *** core/can_payload_pkg.sv ***
// Purpose: shared constants for the steering CAN payload sender and checker
// Assumes: one 8-byte payload moves over the link one byte per cycle
// Notes: crc is msb-first, non-reflected, no final xor
//
// Functional notes
// - speed message expected every 100 ms
// - speed byte 2 top bits give direction
// - speed bytes 3-4, above 64255 not available
// - speed sequence nibble increments, wraps 15 to 0
// - speed sequence may be used for validity
// - speed bytes 7-8 carry crc16 poly C86C
// - speed message sent on primary and redundant
// - feedback message expected every 50 ms
// - feedback bytes 1-2 flow, above 2000 unavailable
// - feedback bytes 3-4 angle, above 2000 unavailable
// - feedback byte 5 revolutions, 1-80 valid, 255 unavailable
// - feedback sequence nibble increments, wraps 15 to 0
// - feedback bytes 7-8 carry crc16 poly C86C
// - feedback message sent by both controllers
package can_payload_pkg;
   // ***************************************************************
   // framing
   // ***************************************************************
   localparam logic KIND_SPEED = 1'b0;
   localparam logic KIND_FEEDBACK = 1'b1;
   localparam logic CHAN_PRIMARY = 1'b0;
   localparam logic [2:0] PAYLOAD_LAST_IDX = 3'h5;
   localparam logic [2:0] CRC_LO_IDX = 3'h6;
   localparam logic [2:0] CRC_HI_IDX = 3'h7;
   localparam logic [2:0] SEQ_IDX = 3'h5;
   localparam logic [2:0] DIR_IDX = 3'h1;
   localparam logic [2:0] SPEED_LO_IDX = 3'h2;
   localparam logic [2:0] SPEED_HI_IDX = 3'h3;
   localparam logic [2:0] FLOW_LO_IDX = 3'h0;
   localparam logic [2:0] FLOW_HI_IDX = 3'h1;
   localparam logic [2:0] ANGLE_LO_IDX = 3'h2;
   localparam logic [2:0] ANGLE_HI_IDX = 3'h3;
   localparam logic [2:0] L2L_IDX = 3'h4;
   localparam logic [2:0] PAD1_IDX = 3'h0;
   localparam logic [2:0] PAD5_IDX = 3'h4;
   localparam logic [7:0] RESERVED_BYTE = 8'hFF;
   localparam logic [5:0] RESERVED_DIR_BITS = 6'h3F;
   localparam logic [3:0] RESERVED_NIBBLE = 4'hF;
   localparam logic [3:0] SEQ_STEP = 4'h1;
   // ***************************************************************
   // field limits
   // ***************************************************************
   localparam logic [1:0] DIR_FORWARD = 2'h0;
   localparam logic [1:0] DIR_REVERSE = 2'h1;
   localparam logic [1:0] DIR_ERROR = 2'h2;
   localparam logic [1:0] DIR_NA = 2'h3;
   localparam logic [15:0] SPEED_MAX = 16'hFAFF;
   localparam logic [15:0] POSITION_MAX = 16'h07D0;
   localparam logic [7:0] L2L_MIN = 8'h01;
   localparam logic [7:0] L2L_MAX = 8'h50;
   localparam logic [7:0] L2L_NA = 8'hFF;
   // ***************************************************************
   // crc
   // ***************************************************************
   localparam logic [15:0] CRC_POLY = 16'hC86C;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int unsigned CLK_KHZ = 10000;
   localparam int unsigned SPEED_PERIOD_MS = 100;
   localparam int unsigned FEEDBACK_PERIOD_MS = 50;
   localparam int unsigned STALE_PERIODS = 2;
   localparam int unsigned STALE_CNT_W = 24;
endpackage : can_payload_pkg

// *** core/can_payload_if.sv ***
// Purpose: byte link between message sender and payload checker
// Assumes: both ends on mclk
// Notes: byte_first marks byte 1 of a frame; kind and channel hold per frame
`timescale 1ns/10ps
interface can_payload_if;
   logic byte_valid;
   logic byte_first;
   logic [7:0] byte_data;
   logic msg_kind;
   logic msg_channel;
   modport sender (
      output byte_valid,
      output byte_first,
      output byte_data,
      output msg_kind,
      output msg_channel
   );
   modport receiver (
      input byte_valid,
      input byte_first,
      input byte_data,
      input msg_kind,
      input msg_channel
   );
endinterface : can_payload_if

// *** core/crc16_byte_step.sv ***
// Purpose: one byte step of the crc16, msb first
// Assumes: caller holds the running value
// Notes: purely combinational, unrolled over 8 bits by a loop
`timescale 1ns/10ps
module crc16_byte_step
   import can_payload_pkg::*;
(
   input wire logic [15:0] crc_in,
   input wire logic [7:0] data_in,
   output logic [15:0] crc_out
);
   always_comb begin
      logic [15:0] c;
      c = crc_in;
      for (int i = 7; i >= 0; i--) begin
         if (c[15] ^ data_in[i]) begin
            c = {c[14:0], 1'b0} ^ CRC_POLY;
         end else begin
            c = {c[14:0], 1'b0};
         end
      end
      crc_out = c;
   end
endmodule : crc16_byte_step

// *** core/payload_sender.sv ***
// Purpose: builds speed and feedback payloads and streams them on the link
// Assumes: send_req is taken only while send_busy is low
// Notes: one sequence counter per kind and channel
`timescale 1ns/10ps
module payload_sender
   import can_payload_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   can_payload_if.sender link,
   input wire logic send_req,
   input wire logic send_kind,
   input wire logic send_channel,
   input wire logic [1:0] travel_direction,
   input wire logic [15:0] vehicle_speed_value,
   input wire logic [15:0] estimated_flow,
   input wire logic [15:0] estimated_wheel_angle,
   input wire logic [7:0] lock_to_lock_revolutions,
   output logic send_busy
);
   typedef enum logic {ST_IDLE = 1'b0, ST_SEND = 1'b1} tx_state_e;
   // ***************************************************************
   // state
   // ***************************************************************
   tx_state_e state_reg;
   logic [2:0] idx_reg;
   logic [7:0] buf_reg [0:5];
   logic [15:0] crc_reg;
   logic [3:0] seq_reg [0:3];
   logic [1:0] stream_reg;
   logic valid_reg;
   logic first_reg;
   logic [7:0] data_reg;
   logic kind_reg;
   logic chan_reg;
   logic busy_reg;
   // ***************************************************************
   // byte selection
   // ***************************************************************
   wire [1:0] req_stream = {send_kind, send_channel};
   wire [3:0] req_seq = seq_reg[req_stream];
   wire start = (state_reg == ST_IDLE) & send_req;
   wire in_payload = idx_reg <= PAYLOAD_LAST_IDX;
   wire [7:0] payload_byte = buf_reg[idx_reg[2:0] & 3'h7];
   wire [15:0] crc_seed = (idx_reg == 3'h0) ? CRC_INIT : crc_reg;
   wire [15:0] crc_step;
   wire [7:0] crc_byte = (idx_reg == CRC_LO_IDX) ? crc_reg[7:0] : crc_reg[15:8];
   wire [7:0] tx_byte = in_payload ? payload_byte : crc_byte;
   wire last_byte = idx_reg == CRC_HI_IDX;
   wire [7:0] seq_byte = {RESERVED_NIBBLE, req_seq};

   crc16_byte_step crc_u (
      .crc_in(crc_seed),
      .data_in(payload_byte),
      .crc_out(crc_step)
   );
   // ***************************************************************
   // frame build and send
   // ***************************************************************
   always_ff @(posedge mclk) begin
      if (start) begin
         if (send_kind == KIND_SPEED) begin
            buf_reg[PAD1_IDX] <= RESERVED_BYTE;
            buf_reg[DIR_IDX] <= {travel_direction, RESERVED_DIR_BITS};
            buf_reg[SPEED_LO_IDX] <= vehicle_speed_value[7:0];
            buf_reg[SPEED_HI_IDX] <= vehicle_speed_value[15:8];
            buf_reg[PAD5_IDX] <= RESERVED_BYTE;
         end else begin
            buf_reg[FLOW_LO_IDX] <= estimated_flow[7:0];
            buf_reg[FLOW_HI_IDX] <= estimated_flow[15:8];
            buf_reg[ANGLE_LO_IDX] <= estimated_wheel_angle[7:0];
            buf_reg[ANGLE_HI_IDX] <= estimated_wheel_angle[15:8];
            buf_reg[L2L_IDX] <= lock_to_lock_revolutions;
         end
         buf_reg[SEQ_IDX] <= seq_byte;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         state_reg <= ST_IDLE;
         idx_reg <= 3'h0;
         crc_reg <= CRC_INIT;
         stream_reg <= 2'h0;
         valid_reg <= 1'b0;
         first_reg <= 1'b0;
         data_reg <= 8'h00;
         kind_reg <= 1'b0;
         chan_reg <= 1'b0;
         busy_reg <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            seq_reg[i] <= 4'h0;
         end
      end else begin
         valid_reg <= 1'b0;
         first_reg <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (send_req) begin
                  state_reg <= ST_SEND;
                  idx_reg <= 3'h0;
                  stream_reg <= req_stream;
                  kind_reg <= send_kind;
                  chan_reg <= send_channel;
                  busy_reg <= 1'b1;
               end
            end
            ST_SEND: begin
               valid_reg <= 1'b1;
               first_reg <= idx_reg == 3'h0;
               data_reg <= tx_byte;
               if (in_payload) begin
                  crc_reg <= crc_step;
               end
               idx_reg <= idx_reg + 3'h1;
               if (last_byte) begin
                  state_reg <= ST_IDLE;
                  busy_reg <= 1'b0;
                  seq_reg[stream_reg] <= seq_reg[stream_reg] + SEQ_STEP;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   assign link.byte_valid = valid_reg;
   assign link.byte_first = first_reg;
   assign link.byte_data = data_reg;
   assign link.msg_kind = kind_reg;
   assign link.msg_channel = chan_reg;
   assign send_busy = busy_reg;
endmodule : payload_sender

// *** testbench/link_monitor.sv ***
// Purpose: framing checks on the sender-to-checker byte link
// Assumes: one mclk domain, srst synchronous active high
// Notes: watches only what the sender drives
`timescale 1ns/10ps
module link_monitor
   import can_payload_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic byte_valid,
   input wire logic byte_first,
   input wire logic [7:0] byte_data,
   input wire logic msg_kind,
   input wire logic msg_channel
);
   // ********
   // framing
   // ********
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   wire spd = byte_first && msg_kind == KIND_SPEED;
   first_valid_a: assert property (byte_first |-> byte_valid)
      else $error("first byte without valid");
   frame_len_a: assert property (byte_first |-> byte_valid [*8] ##1 !byte_valid)
      else $error("frame not eight bytes");
   one_first_a: assert property (byte_first |=> !byte_first [*7])
      else $error("restart inside frame");
   kind_hold_a: assert property (byte_first |=> $stable({msg_kind, msg_channel}) [*7])
      else $error("kind moved inside frame");
   pad_byte1_a: assert property (spd |-> byte_data == RESERVED_BYTE)
      else $error("speed byte 1 not all ones");
   dir_pad_a: assert property (spd |=> byte_data[5:0] == RESERVED_DIR_BITS)
      else $error("direction padding wrong");
   pad_byte5_a: assert property (spd |-> ##4 byte_data == RESERVED_BYTE)
      else $error("speed byte 5 not all ones");
   seq_pad_a: assert property (byte_first |-> ##5 byte_data[7:4] == RESERVED_NIBBLE)
      else $error("sequence byte padding wrong");
   // a speed frame, a feedback frame and a redundant one must all be seen
   cover property (spd);
   cover property (byte_first && msg_kind == KIND_FEEDBACK);
   cover property (byte_first && msg_channel);
endmodule : link_monitor

// *** testbench/steering_can_payload_checker_bench.sv ***
// Purpose: sender and checker back to back, plus a checker fed faulty frames
// Assumes: 10 MHz mclk, short stale limits
// Notes: the fault path needs its own link since the sender never errs
`timescale 1ns/10ps
module steering_can_payload_checker_bench;
   // ********
   // signals
   // ********
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic send_req = 1'b0;
   logic send_kind = 1'b0;
   logic send_channel = 1'b0;
   logic seq_en2 = 1'b1;
   logic [1:0] d_dir = 2'h0;
   logic [15:0] d_sp = 16'h0000;
   logic [15:0] d_fl = 16'h0000;
   logic [15:0] d_an = 16'h0000;
   logic [7:0] d_l2 = 8'h00;
   logic busy, ok, ce, se, rk, rc, sna, fna, ana, lna, lres, sst, fst, ok2, ce2, se2, fst2;
   logic [1:0] dir;
   logic [15:0] sp, fl, an, fl2;
   logic [15:0] fexp = 16'hFFFF;
   logic [7:0] l2;
   logic [7:0] q[$];
   logic [15:0] spt[5] = '{16'h0000, 16'hFAFF, 16'hFB00, 16'hFFFF, 16'h1234};
   logic [15:0] flt[5] = '{16'h0000, 16'h07D0, 16'h07D1, 16'hFFFF, 16'h03E8};
   logic [7:0] l2t[5] = '{8'h00, 8'h01, 8'h50, 8'h51, 8'hFF};
   int seqm[4] = '{0, 0, 0, 0};
   int e_dir = 3, e_sp = 65535, e_fl = 65535, e_an = 65535, e_l2 = 255;
   integer failures = 0;
   integer n_checks = 0;
   integer seed = 32'hFD7BEABF;
   can_payload_if link();
   can_payload_if link2();
   always #50 mclk = ~mclk;
   payload_sender payload_sender_inst (.mclk(mclk), .srst(srst), .link(link),
      .send_req(send_req), .send_kind(send_kind), .send_channel(send_channel),
      .travel_direction(d_dir), .vehicle_speed_value(d_sp), .estimated_flow(d_fl),
      .estimated_wheel_angle(d_an), .lock_to_lock_revolutions(d_l2), .send_busy(busy));
   payload_checker #(.SPEED_STALE_CYC(200), .FEEDBACK_STALE_CYC(100)) payload_checker_inst (
      .mclk(mclk), .srst(srst), .link(link), .seq_check_en(1'b1), .msg_ok(ok),
      .crc_error(ce), .seq_error(se), .rx_kind(rk), .rx_channel(rc), .travel_direction(dir),
      .vehicle_speed_value(sp), .speed_not_available(sna), .estimated_flow(fl),
      .flow_not_available(fna), .estimated_wheel_angle(an), .angle_not_available(ana),
      .lock_to_lock_revolutions(l2), .l2l_not_available(lna), .l2l_reserved(lres),
      .speed_stale(sst), .feedback_stale(fst));
   payload_checker #(.SPEED_STALE_CYC(200), .FEEDBACK_STALE_CYC(100)) payload_checker_inst2 (
      .mclk(mclk), .srst(srst), .link(link2), .seq_check_en(seq_en2), .msg_ok(ok2),
      .crc_error(ce2), .seq_error(se2), .rx_kind(), .rx_channel(), .travel_direction(),
      .vehicle_speed_value(), .speed_not_available(), .estimated_flow(fl2),
      .flow_not_available(), .estimated_wheel_angle(), .angle_not_available(),
      .lock_to_lock_revolutions(), .l2l_not_available(), .l2l_reserved(),
      .speed_stale(), .feedback_stale(fst2));
   link_monitor link_monitor_inst (.mclk(mclk), .srst(srst), .byte_valid(link.byte_valid),
      .byte_first(link.byte_first), .byte_data(link.byte_data),
      .msg_kind(link.msg_kind), .msg_channel(link.msg_channel));
   // ********
   // tasks
   // ********
   task automatic chk(input logic c, input string m);
      n_checks++;
      if (c !== 1'b1) begin
         failures++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : chk
   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] r;
      r = 16'hFFFF;
      for (int i = 0; i < 6; i++) begin
         r = r ^ {b[i], 8'h00};
         for (int j = 0; j < 8; j++) begin
            r = r[15] ? ((r << 1) ^ 16'hC86C) : (r << 1);
         end
      end
      return r;
   endfunction : crc16
   // bounded wait for a result pulse; bytes seen on the main link are kept
   task automatic wait_res(output logic [2:0] p);
      q = {};
      p = 3'h0;
      for (int t = 0; t < 30 && p == 3'h0; t++) begin
         @(negedge mclk);
         if (link.byte_valid === 1'b1) q.push_back(link.byte_data);
         p = {se, ce, ok} | {se2, ce2, ok2};
      end
   endtask : wait_res
   task automatic send(input logic [6:0] i);
      logic [2:0] p;
      int s;
      @(posedge mclk);
      send_req <= 1'b1;
      send_kind <= i[0];
      send_channel <= i[3];
      d_dir <= i[2:1];
      d_sp <= i < 10 ? spt[i >> 1] : 16'($random(seed));
      d_fl <= i < 10 ? flt[i >> 1] : 16'($random(seed));
      d_an <= i < 10 ? flt[4 - (i >> 1)] : 16'($random(seed));
      d_l2 <= i < 10 ? l2t[i >> 1] : 8'($random(seed));
      @(posedge mclk);
      send_req <= 1'b0;
      @(negedge mclk);
      chk(busy === 1'b1, "busy missing");
      wait_res(p);
      s = i[0] * 2 + i[3];
      chk(p === 3'h1, "frame refused");
      chk(busy === 1'b0, "busy stuck");
      chk(sst === 1'b0 && fst === 1'b0, "stale in traffic");
      chk(q.size() == 8 && {q[7], q[6]} === crc16(q), "crc bytes");
      chk(q[5][3:0] === 4'(seqm[s]), "sequence");
      seqm[s] = (seqm[s] + 1) % 16;
      chk(rk === i[0] && rc === i[3], "kind or channel");
      if (i[0] === 1'b0) begin
         chk({q[3], q[2]} === d_sp && q[1][7:6] === d_dir, "speed bytes");
         e_dir = d_dir;
         e_sp = d_sp;
      end else begin
         chk({q[1], q[0]} === d_fl && {q[3], q[2]} === d_an, "feedback bytes");
         e_fl = d_fl;
         e_an = d_an;
         e_l2 = d_l2;
      end
      chk(dir === 2'(e_dir), "direction");
      chk(sp === 16'(e_sp) && sna === (e_sp > 64255), "speed");
      chk(fl === 16'(e_fl) && fna === (e_fl > 2000), "flow");
      chk(an === 16'(e_an) && ana === (e_an > 2000), "angle");
      chk(l2 === 8'(e_l2) && lna === (e_l2 == 255), "revolutions");
      chk(lres === (e_l2 == 0 || (e_l2 > 80 && e_l2 < 255)), "reserved revs");
   endtask : send
   task automatic raw(input logic [3:0] sq, input logic bad, input logic [2:0] want,
                      input logic [15:0] f);
      logic [2:0] p;
      logic [15:0] c;
      q = '{f[7:0], f[15:8], 8'h10, 8'h02, 8'h20, {4'hF, sq}};
      c = crc16(q) ^ {15'h0000, bad};
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      foreach (q[j]) begin
         @(posedge mclk);
         link2.byte_valid <= 1'b1;
         link2.byte_first <= (j == 0);
         link2.byte_data <= q[j];
      end
      @(posedge mclk);
      link2.byte_valid <= 1'b0;
      wait_res(p);
      if (want == 3'h1) fexp = f;
      chk(p === want && fl2 === fexp, "fault path");
   endtask : raw
   task automatic tally_and_finish();
      if (failures == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish
   // ********
   // sequence
   // ********
   initial begin
      link2.byte_valid = 1'b0;
      link2.byte_first = 1'b0;
      link2.byte_data = 8'h00;
      link2.msg_kind = 1'b1;
      link2.msg_channel = 1'b0;
      repeat (5) @(posedge mclk);
      srst <= 1'b0;
      for (int i = 0; i < 72; i++) send(7'(i));
      raw(4'h5, 1'b0, 3'h1, 16'h0100);
      raw(4'h6, 1'b0, 3'h1, 16'h0200);
      raw(4'h8, 1'b0, 3'h4, 16'h0300);
      raw(4'h9, 1'b0, 3'h1, 16'h0400);
      raw(4'hA, 1'b1, 3'h2, 16'h0500);
      raw(4'hA, 1'b0, 3'h1, 16'h0600);
      @(posedge mclk);
      seq_en2 <= 1'b0;
      raw(4'h3, 1'b0, 3'h1, 16'h0700);
      chk(fst2 === 1'b0, "stale too early");
      // the stale limit is 100 cycles here, so the flag rises on cycle 101
      repeat (100) @(negedge mclk);
      chk(fst2 === 1'b0, "stale early");
      @(negedge mclk);
      chk(fst2 === 1'b1, "stale missing");
      repeat (100) @(negedge mclk);
      chk(sst === 1'b1 && fst === 1'b1, "main stale missing");
      tally_and_finish();
   end
   // the whole run needs about 1060 cycles
   initial begin
      repeat (5000) @(posedge mclk);
      failures++;
      tally_and_finish();
   end
endmodule : steering_can_payload_checker_bench
